// ---- hpsh_map.vh ----
`ifndef HPSH_MAP_VH
`define HPSH_MAP_VH
// Access type select codes (two bits)
`define HPSH_SEL_CTRL 2'h0
`define HPSH_SEL_ADDR 2'h1
`define HPSH_SEL_DATA_INC 2'h2
`define HPSH_SEL_DATA_FIX 2'h3
// Port widths
`define HPSH_DATA_W 32
`define HPSH_HALF_W 16
// Minimum strobe low / high time in CPU clocks (4P)
`define HPSH_STB_MIN_CYC 4
`endif

// ---- hpsh_sync.v ----
`timescale 1ns/100ps
module hpsh_sync #(
	parameter W = 1
) (
	input wire core_clk_in, // Core clock
	input wire reset_n_in, // Synchronous reset, active low
	input wire clk_en_in, // Clock enable
	input wire [W-1:0] async_in, // Asynchronous pins
	output reg [W-1:0] sync_out // Synchronised copy
);
	reg [W-1:0] meta_r;

	// Two-stage synchroniser; first stage feeds only the second
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			meta_r <= {W{1'b1}};
			sync_out <= {W{1'b1}};
		end else if (clk_en_in) begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // hpsh_sync

// ---- hpsh_port.v ----
`timescale 1ns/100ps
`include "hpsh_map.vh"
// Behaviour
// - Strobe is not(ds1 xor ds2) or cs
// - Data read start fetches (not a 16-bit high half), ready waits
// - Data write waits while buffer full
// - Selects sampled at strobe or address strobe
module hpsh_port #(
	parameter DW = `HPSH_DATA_W,
	parameter HW = `HPSH_HALF_W
) (
	input wire core_clk_in, // Core clock, 40 MHz
	input wire reset_n_in, // Synchronous reset, active low
	input wire clk_en_in, // Freezes all state when low
	input wire sixteen_bit_mode_in, // High: 16-bit bus, low: 32-bit
	input wire port_chip_select_n_in, // Chip select pin, active low
	input wire data_strobe_one_in, // Data strobe one pin
	input wire data_strobe_two_in, // Data strobe two pin
	input wire address_strobe_n_in, // Address strobe pin, tie high if unused
	input wire [1:0] access_type_select_in, // Access type select pins
	input wire read_write_select_in, // High read, low write
	input wire halfword_select_in, // Half-word select, 16-bit mode
	input wire [DW-1:0] port_data_bus_in, // Data bus pins, input side
	output reg [DW-1:0] port_data_bus_out, // Data bus pins, output side
	output reg port_data_bus_oe_out, // Data bus drive enable
	output reg port_ready_n_out, // Ready pin, low when done
	output reg fetch_req_out, // Fetch pulse to address generator
	input wire fetch_done_in, // Fetched word valid, same clock
	input wire [DW-1:0] fetch_data_in, // Fetched word
	output reg wr_valid_out, // Write word pulse to buffer
	output reg [DW-1:0] wr_data_out, // Write word
	input wire wr_full_in, // Write buffer full, same clock
	output reg [1:0] acc_type_out, // Type of current access
	output reg acc_start_out // Access start pulse, any type
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_DONE = 2'h2;
	localparam NPIN = 8;

	wire [NPIN-1:0] pins_s;
	wire cs_n_s = pins_s[0];
	wire ds1_s = pins_s[1];
	wire ds2_s = pins_s[2];
	wire as_n_s = pins_s[3];
	wire [1:0] type_s = pins_s[5:4];
	wire rw_s = pins_s[6];
	wire hw_s = pins_s[7];
	wire [DW-1:0] data_s;

	reg [1:0] state_r, state_nxt;
	reg stb_n_d_r, as_n_d_r;
	reg as_seen_r;
	reg [1:0] sel_type_r;
	reg sel_rw_r, sel_hw_r;
	reg [DW-1:0] word_r;
	reg [HW-1:0] low_half_r;
	reg is_data_r;
	reg need_fetch_pend;

	hpsh_sync #(.W(NPIN)) u_sync_ctl (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.clk_en_in(clk_en_in),
		.async_in({halfword_select_in, read_write_select_in, access_type_select_in,
			address_strobe_n_in, data_strobe_two_in, data_strobe_one_in,
			port_chip_select_n_in}),
		.sync_out(pins_s)
	);
	hpsh_sync #(.W(DW)) u_sync_dat (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.clk_en_in(clk_en_in),
		.async_in(port_data_bus_in),
		.sync_out(data_s)
	);

	// Combined strobe, active low
	wire stb_n = ~(ds1_s ^ ds2_s) | cs_n_s;
	wire stb_fall = stb_n_d_r & ~stb_n;
	wire stb_rise = ~stb_n_d_r & stb_n;
	// Address strobe leads the data strobe, so it is taken while idle
	wire as_fall = as_n_d_r & ~as_n_s & (state_r == ST_IDLE);
	// Address strobe latched selects take precedence over strobe edge
	wire [1:0] q_type = as_seen_r ? sel_type_r : type_s;
	wire q_rw = as_seen_r ? sel_rw_r : rw_s;
	wire q_hw = as_seen_r ? sel_hw_r : hw_s;
	wire q_data = (q_type == `HPSH_SEL_DATA_INC) | (q_type == `HPSH_SEL_DATA_FIX);
	// Only first half (or full word) of a read fetches
	wire need_fetch = q_data & q_rw & (~sixteen_bit_mode_in | ~q_hw);
	wire sel_now_data = (sel_type_r == `HPSH_SEL_DATA_INC) |
		(sel_type_r == `HPSH_SEL_DATA_FIX);
	wire wr_word = ~sel_rw_r & (~sixteen_bit_mode_in | sel_hw_r);

	// Handshake state; ready released only once access can finish
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (stb_fall) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Read fetch pending or write buffer full keeps ready high
				if (is_data_r & sel_rw_r & ~fetch_done_in & need_fetch_pend) begin
					state_nxt = ST_WAIT;
				end else if (is_data_r & ~sel_rw_r & wr_full_in) begin
					state_nxt = ST_WAIT;
				end else begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				// Strobe release ends access; host must wait for ready
				if (stb_n) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Main sequential logic
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			state_r <= ST_IDLE;
			stb_n_d_r <= 1'b1;
			as_n_d_r <= 1'b1;
			as_seen_r <= 1'b0;
			sel_type_r <= 2'h0;
			sel_rw_r <= 1'b1;
			sel_hw_r <= 1'b0;
			word_r <= {DW{1'b0}};
			low_half_r <= {HW{1'b0}};
			is_data_r <= 1'b0;
			need_fetch_pend <= 1'b0;
			port_data_bus_out <= {DW{1'b0}};
			port_data_bus_oe_out <= 1'b0;
			port_ready_n_out <= 1'b1;
			fetch_req_out <= 1'b0;
			wr_valid_out <= 1'b0;
			wr_data_out <= {DW{1'b0}};
			acc_type_out <= 2'h0;
			acc_start_out <= 1'b0;
		end else if (clk_en_in) begin
			state_r <= state_nxt;
			stb_n_d_r <= stb_n;
			as_n_d_r <= as_n_s;
			fetch_req_out <= 1'b0;
			wr_valid_out <= 1'b0;
			acc_start_out <= 1'b0;
			// Only the first address strobe in an access is honoured
			if (as_fall & ~as_seen_r) begin
				as_seen_r <= 1'b1;
				sel_type_r <= type_s;
				sel_rw_r <= rw_s;
				sel_hw_r <= hw_s;
			end
			if (state_r == ST_IDLE && stb_fall) begin
				sel_type_r <= q_type;
				sel_rw_r <= q_rw;
				sel_hw_r <= q_hw;
				is_data_r <= q_data;
				need_fetch_pend <= need_fetch;
				fetch_req_out <= need_fetch;
				acc_type_out <= q_type;
				acc_start_out <= 1'b1;
				port_ready_n_out <= 1'b1;
				port_data_bus_oe_out <= q_rw;
			end
			if (fetch_done_in & need_fetch_pend) begin
				word_r <= fetch_data_in;
				need_fetch_pend <= 1'b0;
			end
			// Drive read data on the same clock that ready falls; second half from held word
			if (state_r == ST_WAIT && state_nxt == ST_DONE) begin
				port_ready_n_out <= 1'b0;
				if (sel_rw_r) begin
					if (sixteen_bit_mode_in) begin
						port_data_bus_out <= sel_hw_r ?
							{{(DW-HW){1'b0}}, word_r[DW-1:HW]} :
							{{(DW-HW){1'b0}}, (need_fetch_pend ? fetch_data_in[HW-1:0] :
							word_r[HW-1:0])};
					end else begin
						port_data_bus_out <= need_fetch_pend ? fetch_data_in : word_r;
					end
				end
			end
			// Write data captured at strobe release; halves pair low then high
			if (state_r == ST_DONE && stb_n) begin
				as_seen_r <= 1'b0;
				port_data_bus_oe_out <= 1'b0;
				port_ready_n_out <= 1'b1;
				if (~sel_rw_r & sixteen_bit_mode_in & ~sel_hw_r) begin
					low_half_r <= data_s[HW-1:0];
				end
				if (sel_now_data & wr_word) begin
					wr_valid_out <= 1'b1;
					wr_data_out <= sixteen_bit_mode_in ?
						{data_s[HW-1:0], low_half_r} : data_s;
				end
			end
		end
	end

	wire unused_rise = stb_rise;
endmodule // hpsh_port

// ---- hpsh_mem_model.sv ----
`timescale 1ns/100ps
module hpsh_mem_model (
	input wire core_clk_in, // Clock
	input wire fetch_req_in, // Fetch
	output reg fetch_done_out = 1'h0, // Loaded
	output wire [31:0] fetch_data_out // Word
);
	reg [2:0] cnt_r = 3'h0;
	// Slow memory: answers five cycles after a fetch
	always @(posedge core_clk_in) begin
		fetch_done_out <= cnt_r == 3'h1;
		cnt_r <= fetch_req_in ? 3'h5 : cnt_r - (cnt_r != 3'h0);
	end
	// Inverse outside the pulse, so stale data shows
	assign fetch_data_out = fetch_done_out ? 32'hA5C3_1E07 : 32'h5A3C_E1F8;
endmodule // hpsh_mem_model

// ---- hpsh_port_checker.sv ----
`timescale 1ns/100ps
module hpsh_port_checker (
	input wire core_clk_in, // Clock
	input wire reset_n_in, // Reset
	input wire port_chip_select_n_in, // Pin
	input wire data_strobe_one_in, // Pin
	input wire data_strobe_two_in, // Pin
	input wire read_write_select_in, // Pin
	input wire port_ready_n_out, // Pin
	input wire fetch_req_out, // Fetch
	input wire fetch_done_in, // Loaded
	input wire wr_full_in, // Full
	input wire acc_start_out // Start
);
	// Strobe seen at the pins; sync flops delay it
	wire stb = ~(data_strobe_one_in ^ data_strobe_two_in) | port_chip_select_n_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_start; ##[2:5] acc_start_out; endsequence
	sequence s_wait; port_ready_n_out ##1 port_ready_n_out; endsequence
	a_strobe_start:
		assert property ($fell(stb) |-> s_start) else $error("no start");
	a_fetch_wait:
		assert property (fetch_req_out |-> s_wait) else $error("early ready");
	a_load_ready:
		assert property (fetch_done_in && port_ready_n_out |=> !port_ready_n_out) else $error("late");
	a_full_wait:
		assert property (wr_full_in && !read_write_select_in && port_ready_n_out
			|=> port_ready_n_out) else $error("full ignored");
	a_fetch_start:
		assert property (fetch_req_out |-> acc_start_out) else $error("stray fetch");
endmodule // hpsh_port_checker
bind hpsh_port hpsh_port_checker u_chk (.*);

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
	reg core_clk_in = 1'h0, reset_n_in = 1'h0, clk_en_in = 1'h1, sixteen_bit_mode_in = 1'h0;
	reg port_chip_select_n_in = 1'h1, data_strobe_one_in = 1'h1, data_strobe_two_in = 1'h1;
	reg address_strobe_n_in = 1'h1, read_write_select_in = 1'h1, halfword_select_in = 1'h0;
	reg wr_full_in = 1'h0;
	reg o = 1'h0;
	reg [1:0] access_type_select_in = 2'h0;
	reg [31:0] port_data_bus_in = 32'h0, wd = 32'h0, q;
	wire [31:0] port_data_bus_out, fetch_data_in, wr_data_out;
	wire [1:0] acc_type_out;
	wire port_data_bus_oe_out, port_ready_n_out, fetch_req_out, fetch_done_in, wr_valid_out;
	wire acc_start_out;
	integer n_fail = 0, n_tests = 0, nf = 0, nw = 0, cyc = 0, w, s, f;
	hpsh_port dut (.*);
	hpsh_mem_model mem (.core_clk_in, .fetch_req_in(fetch_req_out),
		.fetch_done_out(fetch_done_in), .fetch_data_out(fetch_data_in));
	initial forever #12.5 core_clk_in = ~core_clk_in;
	// Pulse tallies; the run is ended and failed at cycle 2000
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		nf <= nf + fetch_req_out;
		nw <= nw + wr_valid_out;
		wd <= wr_valid_out ? wr_data_out : wd;
		if (cyc == 2000)
			end_of_test(1);
	end
	task chk(input [39:0] nm, input [31:0] e, input [31:0] g);
		n_tests = n_tests + 1;
		if (e !== g) begin
			n_fail = n_fail + 1;
			$display("BAD %0s exp %h got %h", nm, e, g);
		end
	endtask
	task end_of_test(input integer extra);
		n_fail = n_fail + extra;
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Selects first, strobe low until ready, then a gap
	task acc(input r, input [1:0] t, input h, input [31:0] d);
		read_write_select_in = r;
		access_type_select_in = t;
		halfword_select_in = h;
		port_data_bus_in = d;
		@(posedge core_clk_in) #1 data_strobe_one_in = 1'h0;
		port_chip_select_n_in = 1'h0;
		for (w = 0; w < 60 && port_ready_n_out !== 1'h0; w = w + 1)
			@(posedge core_clk_in) #1;
		q = port_data_bus_out;
		o = port_data_bus_oe_out;
		data_strobe_one_in = 1'h1;
		port_chip_select_n_in = 1'h1;
		repeat (6) @(posedge core_clk_in);
		#1;
	endtask
	task rst(input m);
		reset_n_in = 1'h0;
		sixteen_bit_mode_in = m;
		repeat (20) @(posedge core_clk_in);
		#1 reset_n_in = 1'h1;
	endtask
	// Every type code; only data types fetch
	task t_types;
		for (s = 0; s < 4; s = s + 1) begin
			f = nf;
			acc(1'h1, s[1:0], 1'h0, 32'h0);
			chk("fetch", s / 2, nf - f);
		end
		chk("rdata", 32'hA5C3_1E07, q);
		chk("oe", 1'h1, o);
	endtask
	// Selects latched by the address strobe, then changed before the strobe
	task t_as;
		f = nf;
		read_write_select_in = 1'h1;
		access_type_select_in = 2'h3;
		@(posedge core_clk_in) #1 address_strobe_n_in = 1'h0;
		@(posedge core_clk_in) #1;
		acc(1'h0, 2'h0, 1'h0, 32'h0);
		address_strobe_n_in = 1'h1;
		chk("fetch", f + 1, nf);
		chk("rdata", 32'hA5C3_1E07, q);
		chk("oe", 1'h1, o);
		chk("atype", 2'h3, acc_type_out);
	endtask
	// Full buffer holds the host off for ten cycles
	task t_full;
		s = nw;
		wr_full_in = 1'h1;
		fork
			acc(1'h0, 2'h2, 1'h0, 32'h3C5A_9617);
			#250 wr_full_in = 1'h0;
		join
		chk("wait", 1'h1, w > 7);
		chk("oe", 1'h0, o);
		chk("wdata", 32'h3C5A_9617, wd);
		acc(1'h0, 2'h0, 1'h0, 32'h0);
		chk("nwr", s + 1, nw);
	endtask
	// Low half first, one fetch, write joined high over low
	task t_half;
		rst(1'h1);
		f = nf;
		acc(1'h1, 2'h3, 1'h0, 32'h0);
		chk("lo", 32'h1E07, q);
		acc(1'h1, 2'h3, 1'h1, 32'h0);
		chk("hi", 32'hA5C3, q);
		chk("fetch", f + 1, nf);
		acc(1'h0, 2'h3, 1'h0, 32'h1111);
		acc(1'h0, 2'h3, 1'h1, 32'h2222);
		chk("wword", 32'h2222_1111, wd);
	endtask
	initial begin
		rst(1'h0);
		t_types;
		t_full;
		t_as;
		t_half;
		end_of_test(0);
	end
endmodule // tb
